//--- hw/cmrl_clock_manager.sv
// clock manager reset, settle and lock model with derived output clocks
// assumes inputReferenceClock and the reset pin come from outside clk
`timescale 1ns/1ns
module cmrl_clock_manager
  import cmrl_pkg::*;
#(
  parameter int unsigned SETTLE_LEN = SETTLE_CYCLES,
  parameter int unsigned SHIFT_LEN  = SHIFT_CYCLES
)(
  // system
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // reference and control pins
  input  wire logic                  inputReferenceClock,
  input  wire logic                  managerResetPin,
  input  wire logic [2:0]            phaseOffset,
  // outputs
  output cmrl_pkg::cmrl_clocks_t     outClocks,
  output logic                       settled
);
  import cmrl_pkg::*;

  // =========================================================
  // synchronisers
  logic [1:0] refSync_reg, refSync_next;
  logic [1:0] rstSync_reg, rstSync_next;
  logic       refPrev_reg, refPrev_next;
  logic       refRise;
  logic       rstHeld;

  always_comb
  begin
    refSync_next = {refSync_reg[0], inputReferenceClock};
    rstSync_next = {rstSync_reg[0], managerResetPin};
    refPrev_next = refSync_reg[1];
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      refSync_reg <= 2'h0;
      rstSync_reg <= 2'h3;
      refPrev_reg <= 1'h0;
    end
    else
    begin
      refSync_reg <= refSync_next;
      rstSync_reg <= rstSync_next;
      refPrev_reg <= refPrev_next;
    end
  end

  assign refRise = refSync_reg[1] & ~refPrev_reg;
  // the raw pin also forces outputs low at the next clk edge, without waiting for the synchroniser
  assign rstHeld = rstSync_reg[1] | managerResetPin;

  // =========================================================
  // settle sequence
  cmrl_state_t state_reg, state_next;
  logic [31:0] count_reg, count_next;
  logic        lock_reg,  lock_next;
  logic [2:0]  phase_reg, phase_next;

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    lock_next  = 1'b0;
    phase_next = phase_reg;
    unique case (state_reg)
      CMRL_HOLD:
      begin
        count_next = COUNT_RST;
        if (!rstHeld)
          state_next = CMRL_START;
      end
      CMRL_START:
      begin
        if (refRise)
          count_next = count_reg + 32'h1;
        if (count_reg == 32'(START_DELAY))
        begin
          state_next = CMRL_SETTLE;
          count_next = COUNT_RST;
          phase_next = phaseOffset;
        end
      end
      CMRL_SETTLE:
      begin
        count_next = count_reg + 32'h1;
        // an offset needs extra time for shifted clocks to be ready
        if (count_reg >= 32'(SETTLE_LEN)
            + ((phase_reg != PHASE_RST) ? 32'(SHIFT_LEN) : 32'h0))
        begin
          state_next = CMRL_LOCKED;
          lock_next  = 1'b1;
        end
      end
      CMRL_LOCKED:
        lock_next = 1'b1;
    endcase
    if (rstHeld)
    begin
      state_next = CMRL_HOLD;
      lock_next  = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= CMRL_HOLD;
      count_reg <= COUNT_RST;
      lock_reg  <= 1'b0;
      phase_reg <= PHASE_RST;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      lock_reg  <= lock_next;
      phase_reg <= phase_next;
    end
  end

  // =========================================================
  // output clock generation
  // one reference period is PHASE_STEPS clk cycles of phase counter;
  // tracking the reference edge keeps the right frequency
  logic [2:0]   ph_reg, ph_next;
  cmrl_clocks_t clk_reg, clk_next;
  logic [2:0]   shifted;

  // high during the first half of a reference period at the given phase
  function automatic logic inFirstHalf(input logic [2:0] ph);
    return ~ph[2];
  endfunction : inFirstHalf

  always_comb
  begin
    ph_next  = refRise ? 3'h0 : ph_reg + 3'h1;
    // one offset applies to every output so they stay mutually aligned
    shifted  = ph_reg - phase_reg;
    clk_next.zeroDegreeOutput    = inFirstHalf(shifted);
    clk_next.quarterPeriodOutput = inFirstHalf(shifted - 3'h2);
    clk_next.halfPeriodOutput    = ~inFirstHalf(shifted);
    clk_next.doubleRateOutput    = ~shifted[1];
    // start only on a period boundary so the first pulse is never a runt
    if (clk_reg == '0 && shifted != 3'h0)
      clk_next = '0;
    if (state_reg != CMRL_LOCKED || rstHeld)
      clk_next = '0;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ph_reg  <= PHASE_RST;
      clk_reg <= '0;
    end
    else
    begin
      ph_reg  <= ph_next;
      clk_reg <= clk_next;
    end
  end

  assign outClocks = clk_reg;
  assign settled   = lock_reg;

endmodule : cmrl_clock_manager

//--- hw/cmrl_pkg.sv
// package for the clock manager reset and lock model
// assumes a single 100 MHz system clock drives every clocked process
package cmrl_pkg;

  // =========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned RST_MIN_MS      = 200;
  localparam int unsigned RST_MIN_CYCLES  =
    (RST_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned START_DELAY     = 4;
  localparam int unsigned SETTLE_CYCLES   = 64;
  localparam int unsigned SHIFT_CYCLES    = 16;
  localparam int unsigned PHASE_STEPS     = 8;

  // =========================================================
  // reset values
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [2:0]  PHASE_RST = 3'h0;

  // =========================================================
  // settle sequence states, gray along the path
  typedef enum logic [1:0] {
    CMRL_HOLD   = 2'b00,
    CMRL_START  = 2'b01,
    CMRL_SETTLE = 2'b11,
    CMRL_LOCKED = 2'b10
  } cmrl_state_t;

  // =========================================================
  // output clock bundle
  typedef struct packed {
    logic zeroDegreeOutput;
    logic quarterPeriodOutput;
    logic halfPeriodOutput;
    logic doubleRateOutput;
  } cmrl_clocks_t;

endpackage : cmrl_pkg

//--- sim/cmrl_clock_manager_bench.sv
// bench: reset, lock time and output rates
// assumes the user model drives reference and reset pin
`timescale 1ns/1ns
module cmrl_clock_manager_bench;
  import cmrl_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, rstReq = 1'b0, refClk, rstPin, settled;
  logic [2:0] phaseOffset = 3'h0;
  cmrl_clocks_t outClocks, p;
  int errorCnt = 0, checksDone = 0, seed = 66, cyc = 0, n, m, lo;
  initial forever #5 clk = !clk;
  cmrl_user_model #(.PULSE(20)) user_u (.clk(clk), .rstReq(rstReq),
    .refClk(refClk), .rstPin(rstPin));
  cmrl_clock_manager #(.SETTLE_LEN(4), .SHIFT_LEN(2)) dut_u (.clk(clk),
    .resetn(resetn), .inputReferenceClock(refClk),
    .managerResetPin(rstPin), .phaseOffset(phaseOffset),
    .outClocks(outClocks), .settled(settled));
  // ====
  // compare and close
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic endSim();
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : endSim
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errorCnt++;
      endSim();
    end
  end
  // ====
  // reset, lock, then count output edges over 32 cycles
  initial
  begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rstReq = 1'b1;
      phaseOffset = i == 0 ? 3'h0 : 3'($random(seed)) | 3'h1;
      @(negedge clk);
      rstReq = 1'b0;
      repeat (19) @(negedge clk);
      chk({settled, 4'(outClocks)}, 32'h0);
      for (n = 0; settled !== 1'b1 && n < 300; n++) @(negedge clk);
      // model: settle plus shift when an offset is set
      lo = 4 + (i > 0 ? 2 : 0);
      chk(32'(n >= lo && n <= lo + 60), 32'h1);
      // outputs start on the first period boundary after lock
      for (m = 0; outClocks.zeroDegreeOutput !== 1'b1 && m < 16; m++)
        @(negedge clk);
      chk(32'(m < 10), 32'h1);
      p = outClocks;
      n = 0;
      m = 0;
      repeat (32)
      begin
        @(negedge clk);
        n += int'(outClocks.zeroDegreeOutput !== p.zeroDegreeOutput);
        m += int'(outClocks.doubleRateOutput !== p.doubleRateOutput);
        p = outClocks;
      end
      chk(n, 8);
      chk(m, 16);
      $display("test %0d done", i);
    end
    endSim();
  end
endmodule : cmrl_clock_manager_bench

//--- sim/cmrl_clock_manager_properties.sv
// checker: lock and output phase relations
// assumes reference-rate outputs of period 8 clk, double rate output of period 4 clk
`timescale 1ns/1ns
module cmrl_checker
  import cmrl_pkg::*;
#(parameter int unsigned SETTLE_LEN = 4,
  parameter int unsigned SHIFT_LEN  = 2)(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              inputReferenceClock,
  input wire logic              managerResetPin,
  input wire logic [2:0]        phaseOffset,
  input cmrl_pkg::cmrl_clocks_t outClocks,
  input wire logic              settled
);
  // ====
  // relations, off in system reset
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire r = managerResetPin;
  wire s = settled;
  wire z = outClocks.zeroDegreeOutput;
  wire q = outClocks.quarterPeriodOutput;
  wire h = outClocks.halfPeriodOutput;
  wire d = outClocks.doubleRateOutput;
  // pin is synced twice, so allow four edges
  clk_low_a: assert property (r[*4] |-> outClocks == 4'h0)
    else $error("clock high in reset");
  lock_low_a: assert property (r[*4] |-> !s)
    else $error("lock high in reset");
  lock_late_a: assert property ($rose(s) |-> !$past(r, 8))
    else $error("lock too early");
  zero_rate_a: assert property ($rose(z) && s ##8 s |-> $rose(z))
    else $error("zero output period");
  dbl_rate_a: assert property ($rose(d) && s ##4 s |-> $rose(d))
    else $error("double output period");
  edge_align_a: assert property ($rose(z) && s |-> $rose(d))
    else $error("zero and double apart");
  quarter_lag_a: assert property ($rose(z) && s ##2 s |-> $rose(q))
    else $error("quarter output phase");
  half_lag_a: assert property ($rose(z) && s ##4 s |-> $rose(h))
    else $error("half output phase");
endmodule : cmrl_checker
bind cmrl_clock_manager cmrl_checker #(.SETTLE_LEN(SETTLE_LEN),
  .SHIFT_LEN(SHIFT_LEN)) chk_u (.clk, .resetn, .inputReferenceClock,
  .managerResetPin, .phaseOffset, .outClocks, .settled);

//--- sim/cmrl_user_model.sv
// user side: reference clock and reset pulses
// assumes clk at 100 MHz, pulse length shortened
`timescale 1ns/1ns
module cmrl_user_model #(parameter int PULSE = 20)(
  input  wire logic clk,
  input  wire logic rstReq,
  output logic      refClk,
  output logic      rstPin
);
  // ====
  // state
  int c = 0;
  int n = PULSE;
  initial refClk = 1'b0;
  initial rstPin = 1'b1;
  always @(posedge clk) n <= rstReq ? PULSE : (n > 0 ? n - 1 : 0);
  // drive off the sampling edge, reference period 8 clk
  always @(negedge clk)
  begin
    c = (c + 1) % 4;
    if (c == 0) refClk <= !refClk;
    rstPin <= n > 0;
  end
endmodule : cmrl_user_model
